/* logic/ddc_drive_port.sv */
// disk drive control port: port cycles on the shared lines, status decode,
// step generation and parameter block fetch / write-back over the bus master
// assumes external latches on outLatchStrobe and buffers on inBufferEnable
//
// Operation
// R01: port cycles only during local transfer mode
// R02: output cycle pulses latch strobe with word
// R03: input cycle enables buffers, samples status
// R04: seven status inputs, all active high
// R05: either track-zero or either write line counts
// R06: drive never raises both paired lines
// R07: input bit map index ready seek zero guard
// R08: drive holds index wider than minimum
// R09: bits 12..15 select drives 0..3
// R10: head number on bits 0..4, bit5 unused
// R11: side bit zero for single-sided floppy
// R12: fixed-width step pulses, gap from rate
// R13: bit 7 high steps toward spindle
// R14: bits 8..11 current, motor, comp, load
// R15: external octal registers capture on strobe
// R16: drive number indexes pointer table entry
// R17: write status before signalling completion
// R18: host leaves block alone during command
// R19: host validates parameters and computed values
// R20: read block at start, write back end
// R21: block transfers arbitrate then handshake
// R22: static fields untouched, dynamic fields updated
// R23: four byte pointer base, cleared by reset
// R24: external latches hold word between strobes
`timescale 1ns/1ps
`include "ddc_params.svh"
module ddc_drive_port #(
  parameter int STEP_UNIT_CYC = `DDC_STEP_UNIT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  // shared address/data lines and port strobes
  input wire logic localMode,
  input wire ddc_pkg::ddc_word_t adIn,
  output ddc_pkg::ddc_word_t adOut,
  output logic adOe_n,
  output logic outLatchStrobe,
  output logic inBufferEnable,
  // user side control
  input wire logic cmdStart,
  input wire logic [1:0] cmdDrive,
  input wire logic singleSided,
  input wire logic motorOn,
  input wire logic reducedWriteCurrent,
  input wire logic writeCompEnable,
  input wire logic floppyHeadLoad,
  input wire logic [3:0] ptrByteWe,
  input wire logic [7:0] ptrByteIn,
  output logic cmdBusy,
  output logic cmdDone,
  output logic [7:0] cmdStatus,
  output logic driveIndex,
  output logic driveReady,
  output logic seekDone,
  output logic trackZero,
  output logic writeGuard,
  // bus master
  output logic busReq,
  input wire logic busGrant,
  input wire logic busFree,
  output logic busOwn,
  output logic mStrobe,
  output logic mWrite,
  output logic [31:0] mAddr,
  output ddc_pkg::ddc_word_t mWdata,
  input wire ddc_pkg::ddc_word_t mRdata,
  input wire logic mAck
);
  import ddc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  ddc_port_e portState, next_portState; // port cycle sequencer
  ddc_word_t sentWord, next_sentWord; // word last latched outside
  ddc_word_t next_adOut;
  logic [6:0] inBits, next_inBits; // last sampled status bits
  ddc_eng_e engState, next_engState; // parameter block engine
  logic [3:0] xferIdx, next_xferIdx; // which transfer of the command
  logic [1:0] drive, next_drive; // drive being served
  logic [7:0] ptrByte [4]; // pointer table base, byte wide
  logic [7:0] next_ptrByte [4];
  logic [31:0] blockPtr, next_blockPtr; // this drive's parameter block
  logic [7:0] cmdCode, next_cmdCode; // kept to rewrite word 0 intact
  logic [15:0] targetCyl, next_targetCyl;
  logic [15:0] curCyl, next_curCyl;
  logic [4:0] headNum, next_headNum;
  logic [7:0] stepRate, next_stepRate;
  logic [15:0] stepsLeft, next_stepsLeft;
  logic stepDir, next_stepDir;
  logic [7:0] next_cmdStatus;
  logic next_cmdDone;
  logic next_cmdBusy;
  ddc_word_t ctrlWord; // control word to be latched
  logic [31:0] ptrBase;
  logic [4:0] wordNo;
  logic stepBusy, gapBusy, pollBusy;
  logic stepLoad, pollLoad;
  logic [31:0] gapLoadValue;

  assign ptrBase = {ptrByte[3], ptrByte[2], ptrByte[1], ptrByte[0]};

  // ----------------------------------------
  // timers
  // ----------------------------------------
  ddc_down_timer #(.WIDTH(32)) stepWidthTimer (
    .ref_clk(ref_clk), .rst(rst), .load(stepLoad),
    .loadValue(32'(`DDC_STEP_WIDTH_CYC)), .busy(stepBusy)
  );
  // gap runs from the pulse start, so it covers width plus rate units
  assign gapLoadValue = 32'(`DDC_STEP_WIDTH_CYC) + 32'(stepRate) * 32'(STEP_UNIT_CYC);
  ddc_down_timer #(.WIDTH(32)) stepGapTimer (
    .ref_clk(ref_clk), .rst(rst), .load(stepLoad),
    .loadValue(gapLoadValue), .busy(gapBusy)
  );
  ddc_down_timer #(.WIDTH(16)) pollTimer (
    .ref_clk(ref_clk), .rst(rst), .load(pollLoad),
    .loadValue(16'(`DDC_POLL_CYC)), .busy(pollBusy)
  );

  // ----------------------------------------
  // control word composition
  // ----------------------------------------
  always_comb begin
    ctrlWord = '0;
    // head number in binary, bit 5 left at zero
    ctrlWord[`DDC_OUT_HEAD_LSB +: 5] = headNum; // R10
    if (singleSided) begin
      ctrlWord[`DDC_OUT_HEAD_LSB] = 1'b0; // R11
    end
    ctrlWord[`DDC_OUT_STEP] = stepBusy; // R12
    ctrlWord[`DDC_OUT_DIR] = stepDir; // R13
    ctrlWord[`DDC_OUT_REDUCED_CUR] = reducedWriteCurrent; // R14
    ctrlWord[`DDC_OUT_MOTOR] = motorOn; // R14
    ctrlWord[`DDC_OUT_COMP] = writeCompEnable; // R14
    ctrlWord[`DDC_OUT_HEAD_LOAD] = floppyHeadLoad; // R14
    // one select line per drive, only while a command holds the drive
    if (cmdBusy) begin
      ctrlWord[`DDC_OUT_PICK_LSB + drive] = 1'b1; // R09
    end
  end

  // ----------------------------------------
  // port cycle sequencer
  // ----------------------------------------
  // a changed word wins over polling so step edges reach the drive quickly
  always_comb begin
    next_portState = portState;
    next_sentWord = sentWord;
    next_adOut = adOut;
    next_inBits = inBits;
    pollLoad = 1'b0;
    case (portState)
      PORT_IDLE: begin
        // shared lines belong to the port only in local mode
        if (localMode && ctrlWord != sentWord) begin // R01
          next_adOut = ctrlWord;
          next_portState = PORT_OUT_SET;
        end else if (localMode && !pollBusy) begin // R01
          pollLoad = 1'b1;
          next_portState = PORT_IN_EN;
        end
      end
      PORT_OUT_SET: begin
        next_portState = PORT_OUT_STB;
      end
      PORT_OUT_STB: begin
        next_sentWord = adOut; // R02
        next_portState = PORT_OUT_HOLD;
      end
      PORT_OUT_HOLD: begin
        next_portState = PORT_IDLE;
      end
      PORT_IN_EN: begin
        next_portState = PORT_IN_SMP;
      end
      PORT_IN_SMP: begin
        // bits 7 to 15 carry nothing and are dropped
        next_inBits = adIn[6:0]; // R03 R07
        next_portState = PORT_IDLE;
      end
      default: begin
        next_portState = PORT_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      portState <= PORT_IDLE;
      sentWord <= '0;
      adOut <= '0;
      inBits <= '0;
    end else begin
      portState <= next_portState;
      sentWord <= next_sentWord;
      adOut <= next_adOut;
      inBits <= next_inBits;
    end
  end

  // drive the lines through set, strobe and hold so latches see stable data
  assign adOe_n = !(portState == PORT_OUT_SET || portState == PORT_OUT_STB ||
                    portState == PORT_OUT_HOLD);
  assign outLatchStrobe = (portState == PORT_OUT_STB); // R02
  assign inBufferEnable = (portState == PORT_IN_EN || portState == PORT_IN_SMP); // R03

  // ----------------------------------------
  // status decode, all lines active high
  // ----------------------------------------
  // paired lines are ored; a drive never raises both at once
  assign driveIndex = inBits[`DDC_IN_INDEX]; // R04 R07
  assign driveReady = inBits[`DDC_IN_READY]; // R04 R07
  assign seekDone = inBits[`DDC_IN_SEEK_DONE]; // R04 R07
  assign trackZero = inBits[`DDC_IN_TRACK_ZERO_FIRST] |
                     inBits[`DDC_IN_TRACK_ZERO_SECOND]; // R05
  assign writeGuard = inBits[`DDC_IN_WRITE_PROTECT] |
                      inBits[`DDC_IN_WRITE_FAULT]; // R05

  // ----------------------------------------
  // transfer address selection
  // ----------------------------------------
  // 0,1 pointer words; 2..6 block reads; 7,8 block writes
  always_comb begin
    case (xferIdx)
      4'h2: wordNo = `DDC_W_CMD_STATUS;
      4'h3: wordNo = `DDC_W_CYLINDER;
      4'h4: wordNo = `DDC_W_HEAD_SECTOR;
      4'h5: wordNo = `DDC_W_CUR_CYL;
      4'h6: wordNo = `DDC_W_STEP_RATE;
      4'h7: wordNo = `DDC_W_CUR_CYL;
      default: wordNo = `DDC_W_CMD_STATUS;
    endcase
    if (xferIdx < 4'h2) begin
      // each entry is two words, high word first, drive 0 first
      mAddr = ptrBase + {27'h0, drive, 3'h0} - {27'h0, drive, 2'h0} +
              {30'h0, xferIdx[0], 1'b0}; // R16 R23
    end else begin
      mAddr = blockPtr + {26'h0, wordNo, 1'b0};
    end
    // only the dynamic cylinder word and the status byte are written back
    if (xferIdx == 4'h7) begin
      mWdata = targetCyl; // R22
    end else begin
      mWdata = {cmdCode, cmdStatus}; // R22
    end
  end

  assign busReq = (engState == ENG_ARB); // R21
  assign busOwn = (engState == ENG_XFER); // R21
  assign mStrobe = (engState == ENG_XFER); // R21
  assign mWrite = (engState == ENG_XFER) && (xferIdx >= 4'h7);

  // ----------------------------------------
  // parameter block engine
  // ----------------------------------------
  always_comb begin
    next_engState = engState;
    next_xferIdx = xferIdx;
    next_drive = drive;
    next_blockPtr = blockPtr;
    next_cmdCode = cmdCode;
    next_targetCyl = targetCyl;
    next_curCyl = curCyl;
    next_headNum = headNum;
    next_stepRate = stepRate;
    next_stepsLeft = stepsLeft;
    next_stepDir = stepDir;
    next_cmdStatus = cmdStatus;
    next_cmdBusy = cmdBusy;
    next_cmdDone = 1'b0;
    stepLoad = 1'b0;
    for (int i = 0; i < 4; i++) begin
      next_ptrByte[i] = ptrByteWe[i] ? ptrByteIn : ptrByte[i]; // R23
    end
    case (engState)
      ENG_IDLE: begin
        if (cmdStart) begin
          next_drive = cmdDrive;
          next_xferIdx = 4'h0;
          next_cmdBusy = 1'b1;
          next_cmdStatus = `DDC_ST_OK;
          next_engState = ENG_ARB; // R20
        end
      end
      ENG_ARB: begin
        // wait for grant and for the previous master to let go
        if (busGrant && busFree) begin // R21
          next_engState = ENG_XFER;
        end
      end
      ENG_XFER: begin
        if (mAck) begin // R21
          next_xferIdx = xferIdx + 4'h1;
          case (xferIdx)
            4'h0: next_blockPtr = {mRdata, blockPtr[15:0]}; // R16
            4'h1: next_blockPtr = {blockPtr[31:16], mRdata}; // R16
            4'h2: next_cmdCode = mRdata[15:8];
            4'h3: next_targetCyl = mRdata;
            4'h4: next_headNum = mRdata[12:8];
            4'h5: next_curCyl = mRdata;
            4'h6: next_stepRate = mRdata[7:0];
            default: next_cmdCode = cmdCode;
          endcase
          if (xferIdx == 4'h6) begin
            // bus is given back while the heads move
            next_engState = ENG_SEEK; // R20
            if (targetCyl > curCyl) begin
              next_stepDir = 1'b1; // R13
              next_stepsLeft = targetCyl - curCyl;
            end else begin
              next_stepDir = 1'b0; // R13
              next_stepsLeft = curCyl - targetCyl;
            end
            if (!driveReady) begin
              next_stepsLeft = '0;
              next_targetCyl = curCyl;
              next_cmdStatus = `DDC_ST_NOT_READY;
            end
          end else if (xferIdx == 4'h8) begin
            // completion only after the status word is in memory
            next_engState = ENG_DONE; // R17
          end
        end
      end
      ENG_SEEK: begin
        if (!stepBusy && !gapBusy) begin
          if (stepsLeft != '0) begin
            stepLoad = 1'b1; // R12
            next_stepsLeft = stepsLeft - 16'h1;
          end else begin
            next_engState = ENG_ARB; // R20
          end
        end
      end
      ENG_DONE: begin
        next_cmdDone = 1'b1; // R17
        next_cmdBusy = 1'b0;
        next_engState = ENG_IDLE;
      end
      default: begin
        next_engState = ENG_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      engState <= ENG_IDLE;
      xferIdx <= '0;
      drive <= '0;
      blockPtr <= '0;
      cmdCode <= '0;
      targetCyl <= '0;
      curCyl <= '0;
      headNum <= '0;
      stepRate <= '0;
      stepsLeft <= '0;
      stepDir <= 1'b0;
      cmdStatus <= `DDC_ST_OK;
      cmdBusy <= 1'b0;
      cmdDone <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        ptrByte[i] <= `DDC_PTR_RESET; // R23
      end
    end else begin
      engState <= next_engState;
      xferIdx <= next_xferIdx;
      drive <= next_drive;
      blockPtr <= next_blockPtr;
      cmdCode <= next_cmdCode;
      targetCyl <= next_targetCyl;
      curCyl <= next_curCyl;
      headNum <= next_headNum;
      stepRate <= next_stepRate;
      stepsLeft <= next_stepsLeft;
      stepDir <= next_stepDir;
      cmdStatus <= next_cmdStatus;
      cmdBusy <= next_cmdBusy;
      cmdDone <= next_cmdDone;
      for (int i = 0; i < 4; i++) begin
        ptrByte[i] <= next_ptrByte[i];
      end
    end
  end

endmodule : ddc_drive_port

/* logic/ddc_params.svh */
// constants for the disk drive control port: bit positions, word numbers, timing
// assumes a 250 MHz reference clock; included by bare name
`ifndef DDC_PARAMS_SVH
`define DDC_PARAMS_SVH

// ----------------------------------------
// clock and times
// ----------------------------------------
`define DDC_CLK_PERIOD_PS 4000
`define DDC_STEP_WIDTH_NS 10000
`define DDC_STEP_WIDTH_CYC ((`DDC_STEP_WIDTH_NS * 1000 + `DDC_CLK_PERIOD_PS - 1) / `DDC_CLK_PERIOD_PS)
`define DDC_STEP_UNIT_NS 100000
`define DDC_STEP_UNIT_CYC ((`DDC_STEP_UNIT_NS * 1000 + `DDC_CLK_PERIOD_PS - 1) / `DDC_CLK_PERIOD_PS)
`define DDC_POLL_NS 1000
`define DDC_POLL_CYC ((`DDC_POLL_NS * 1000 + `DDC_CLK_PERIOD_PS - 1) / `DDC_CLK_PERIOD_PS)

// ----------------------------------------
// input port bit positions
// ----------------------------------------
`define DDC_IN_INDEX 0
`define DDC_IN_READY 1
`define DDC_IN_SEEK_DONE 2
`define DDC_IN_TRACK_ZERO_FIRST 3
`define DDC_IN_TRACK_ZERO_SECOND 4
`define DDC_IN_WRITE_PROTECT 5
`define DDC_IN_WRITE_FAULT 6

// ----------------------------------------
// output port bit positions
// ----------------------------------------
`define DDC_OUT_HEAD_LSB 0
`define DDC_OUT_STEP 6
`define DDC_OUT_DIR 7
`define DDC_OUT_REDUCED_CUR 8
`define DDC_OUT_MOTOR 9
`define DDC_OUT_COMP 10
`define DDC_OUT_HEAD_LOAD 11
`define DDC_OUT_PICK_LSB 12

// ----------------------------------------
// parameter block word numbers and status codes
// ----------------------------------------
`define DDC_W_CMD_STATUS 5'd0
`define DDC_W_CYLINDER 5'd8
`define DDC_W_HEAD_SECTOR 5'd9
`define DDC_W_CUR_CYL 5'd10
`define DDC_W_STEP_RATE 5'd24
`define DDC_ST_OK 8'h00
`define DDC_ST_NOT_READY 8'h02
`define DDC_PTR_RESET 8'h00

`endif

/* logic/ddc_pkg.sv */
// types shared by the disk drive control port modules
// assumes ddc_params.svh supplies the numeric constants
package ddc_pkg;

  // ----------------------------------------
  // port cycle sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    PORT_IDLE, PORT_OUT_SET, PORT_OUT_STB, PORT_OUT_HOLD, PORT_IN_EN, PORT_IN_SMP
  } ddc_port_e;

  // ----------------------------------------
  // parameter block engine states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ENG_IDLE, ENG_ARB, ENG_XFER, ENG_SEEK, ENG_DONE
  } ddc_eng_e;

  typedef logic [15:0] ddc_word_t;

endpackage : ddc_pkg

/* logic/ddc_down_timer.sv */
// loadable down counter used for step width, step gap and poll timing
// assumes a synchronous active-high reset
`timescale 1ns/1ps
module ddc_down_timer #(
  parameter int WIDTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  output logic busy
);

  logic [WIDTH-1:0] count; // cycles still to run
  logic [WIDTH-1:0] next_count;

  // ----------------------------------------
  // count down to zero and stop
  // ----------------------------------------
  always_comb begin
    if (load) begin
      next_count = loadValue;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end else begin
      next_count = count;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign busy = (count != '0);

endmodule : ddc_down_timer

/* tb/ddc_port_monitor.sv */
// checker for the drive control port: strobe walks, decode, step width, bus order
// assumes a bind from tb_top onto ddc_drive_port; sees only its ports
`timescale 1ns/1ps
module ddc_port_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire ddc_pkg::ddc_word_t adIn,
  input wire ddc_pkg::ddc_word_t adOut,
  input wire logic adOe_n,
  input wire logic outLatchStrobe,
  input wire logic inBufferEnable,
  input wire logic singleSided,
  input wire logic cmdBusy,
  input wire logic cmdDone,
  input wire logic driveIndex,
  input wire logic driveReady,
  input wire logic seekDone,
  input wire logic trackZero,
  input wire logic writeGuard,
  input wire logic busReq,
  input wire logic busGrant,
  input wire logic busFree,
  input wire logic busOwn,
  input wire logic mStrobe,
  input wire logic mWrite,
  input wire logic [31:0] mAddr,
  input wire logic mAck
);
  import ddc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic [12:0] stepLen; // cycles the step bit stood high, saturating
  logic [12:0] next_stepLen;
  logic wroteBack; // a write transfer was acked since the last done
  logic next_wroteBack;
  // next values; saturation keeps a stuck step bit from wrapping
  always_comb begin
    next_stepLen = adOut[6] ? stepLen + {12'h000, stepLen != 13'h1fff} : 13'h0000;
    next_wroteBack = cmdDone ? 1'b0 : (wroteBack | (mStrobe & mAck & mWrite));
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stepLen <= 13'h0000;
      wroteBack <= 1'b0;
    end else begin
      stepLen <= next_stepLen;
      wroteBack <= next_wroteBack;
    end
  end
  // ----------------------------------------
  // port cycles
  // ----------------------------------------
  sequence s_outWalk;
    ##1 outLatchStrobe ##1 (!outLatchStrobe && !adOe_n) ##1 adOe_n;
  endsequence
  sequence s_inWalk;
    inBufferEnable [*2] ##1 !inBufferEnable;
  endsequence
  a_out_walk: assert property ($fell(adOe_n) |-> s_outWalk)
    else $error("output cycle walk broken");
  a_in_walk: assert property ($rose(inBufferEnable) |-> s_inWalk)
    else $error("input enable not two cycles");
  a_no_contention: assert property (inBufferEnable |-> adOe_n)
    else $error("buffers enabled while driving");
  a_track_zero: assert property ($fell(inBufferEnable) |->
    trackZero == ($past(adIn[3]) | $past(adIn[4]))
    && writeGuard == ($past(adIn[5]) | $past(adIn[6])))
    else $error("paired status lines misread");
  a_status_map: assert property ($fell(inBufferEnable) |->
    {seekDone, driveReady, driveIndex} == $past(adIn[2:0]))
    else $error("status bits misread");
  a_word_map: assert property (outLatchStrobe |-> !adOut[5] && $onehot0(adOut[15:12]))
    else $error("bad output word layout");
  a_side_zero: assert property (outLatchStrobe && singleSided |-> !adOut[0])
    else $error("side bit set on single sided");
  a_step_width: assert property ($fell(adOut[6]) |-> stepLen >= 13'd2495 && stepLen <= 13'd2505)
    else $error("step pulse width wrong");
  // ----------------------------------------
  // bus master
  // ----------------------------------------
  a_req_first: assert property ($rose(cmdBusy) |-> busReq)
    else $error("no bus request after start");
  a_grant_first: assert property ($rose(busOwn) |-> $past(busReq && busGrant && busFree))
    else $error("bus taken without grant");
  a_xfer_hold: assert property (mStrobe && !mAck |=> mStrobe && $stable(mAddr) && $stable(mWrite))
    else $error("transfer changed before ack");
  a_status_first: assert property (cmdDone |-> wroteBack)
    else $error("done before status write");
  a_done_pulse: assert property (cmdDone |=> !cmdDone)
    else $error("done longer than one cycle");
endmodule : ddc_port_monitor

/* tb/ddc_drive_model.sv */
// drive side: octal output latches, status buffers, floating shared lines
// assumes driveStatus comes from the bench, at most one line high within each pair
`timescale 1ns/1ps
module ddc_drive_model (
  input wire logic ref_clk,
  input wire ddc_pkg::ddc_word_t adOut,
  input wire logic adOe_n,
  input wire logic outLatchStrobe,
  input wire logic inBufferEnable,
  input wire logic [6:0] driveStatus,
  output ddc_pkg::ddc_word_t adIn,
  output ddc_pkg::ddc_word_t driveCtl
);
  import ddc_pkg::*;
  ddc_word_t idleNoise; // stands in for undriven lines, changes every cycle
  initial begin
    idleNoise = 16'h5a3c;
    driveCtl = 16'h0000;
  end
  // shared lines: design first, then buffers, else floating
  always_comb begin
    if (!adOe_n) adIn = adOut;
    else if (inBufferEnable) adIn = {idleNoise[15:7], driveStatus};
    else adIn = idleNoise;
  end
  // latches capture only on the strobe and hold in between
  always @(posedge ref_clk) begin
    idleNoise <= ~{idleNoise[14:0], idleNoise[15]};
    if (outLatchStrobe) driveCtl <= adIn;
  end
endmodule : ddc_drive_model

/* tb/tb_top.sv */
// bench for ddc_drive_port: control word, status decode, commands via memory
// assumes ddc_port_monitor and ddc_drive_model compiled before
`timescale 1ns/1ps
module tb_top;
  import ddc_pkg::*;
  localparam int STEP_UNIT = 4; // shortened rate unit keeps seeks brief
  localparam int LIMIT = 40000;
  logic ref_clk, rst, localMode, cmdStart, singleSided, motorOn, reducedWriteCurrent;
  logic writeCompEnable, floppyHeadLoad, cmdBusy, cmdDone, driveIndex, driveReady;
  logic seekDone, trackZero, writeGuard, busReq, busGrant, busFree, busOwn, mStrobe;
  logic mWrite, mAck, adOe_n, outLatchStrobe, inBufferEnable, addrSeen;
  logic [1:0] cmdDrive;
  logic [3:0] ptrByteWe;
  logic [7:0] ptrByteIn, cmdStatus;
  logic [31:0] mAddr, firstAddr;
  logic [6:0] driveStatus; // status lines shown by the drive
  ddc_word_t adIn, adOut, mWdata, mRdata, driveCtl, atStep;
  logic [15:0] mem [int]; // host memory by byte address
  int errTotal, numChecks, cycles, ackWait, stepRises, lastRise, gap;
  ddc_drive_port #(.STEP_UNIT_CYC(STEP_UNIT)) i_dut (.*);
  ddc_drive_model i_drv (.ref_clk(ref_clk), .adOut(adOut), .adOe_n(adOe_n),
    .outLatchStrobe(outLatchStrobe), .inBufferEnable(inBufferEnable),
    .driveStatus(driveStatus), .adIn(adIn), .driveCtl(driveCtl));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    numChecks++;
    if (seen !== want) begin
      errTotal++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // one command: builds the table and block, runs it, checks write-back
  task automatic run_cmd(input int base, drv, input logic ready, side,
                         input logic [15:0] cur, tgt, input logic [4:0] head);
    int blk;
    // block filled with legal values only before the command starts
    blk = 32'h2000 + drv * 256;
    mem[base + drv * 4] = 16'h0000;
    mem[base + drv * 4 + 2] = blk[15:0];
    mem[blk] = 16'h11ff;
    mem[blk + 16] = tgt;
    mem[blk + 18] = {3'h0, head, 8'h07};
    mem[blk + 20] = cur;
    mem[blk + 48] = 16'h0002;
    driveStatus = {5'h00, ready, 1'b0};
    singleSided = side;
    idle(300);
    stepRises = 0;
    addrSeen = 1'b0;
    cmdDrive = drv[1:0];
    cmdStart = 1'b1;
    idle(1);
    cmdStart = 1'b0;
    // memory left untouched until completion
    for (int i = 0; i < 20000 && cmdDone !== 1'b1; i++) idle(1);
    check("status", cmdStatus, ready ? 32'h0 : 32'h2);
    check("word0", mem[blk], ready ? 16'h1100 : 16'h1102);
    check("word10", mem[blk + 20], ready ? tgt : cur);
    check("word8", mem[blk + 16], tgt);
    check("first addr", firstAddr, base + drv * 4);
    check("steps", stepRises, ready ? 2 : 0);
    if (ready) begin
      check("pick", atStep[15:12], 4'h1 << drv);
      check("head", atStep[4:0], side ? {head[4:1], 1'b0} : head);
      check("dir", atStep[7], tgt > cur);
      check("gap", gap >= 2504 && gap <= 2512, 1'b1);
    end
    $display("test command drive %0d done", drv);
  endtask : run_cmd
  // ----------------------------------------
  // host memory and arbiter, driven at falling edge
  // ----------------------------------------
  always @(negedge ref_clk) begin
    busGrant <= busReq;
    // each signal assigned once per falling edge
    if (mStrobe && !mAck && ackWait == 0) begin
      mAck <= 1'b1;
      ackWait <= mAddr[1] ? 2 : 0; // some words answered slowly
      if (mWrite) mem[mAddr] = mWdata;
      mRdata <= mWrite ? ~mRdata : (mem.exists(mAddr) ? mem[mAddr] : 16'h0000);
      if (!addrSeen) firstAddr <= mAddr;
      addrSeen <= 1'b1;
    end else begin
      mAck <= 1'b0;
      mRdata <= ~mRdata;
      if (mStrobe && !mAck) ackWait <= ackWait - 1;
    end
  end
  // step watcher on the latched word
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if ($rose(driveCtl[6])) begin
      stepRises++;
      gap = cycles - lastRise;
      lastRise = cycles;
      atStep = driveCtl;
    end
  end
  // hang guard
  always @(posedge ref_clk) if (cycles == LIMIT) begin
    errTotal++;
    conclude();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] newBase;
    rst = 1'b1; localMode = 1'b0; cmdStart = 1'b0; cmdDrive = 2'h0; singleSided = 1'b0;
    {floppyHeadLoad, writeCompEnable, motorOn, reducedWriteCurrent} = 4'h0;
    ptrByteWe = 4'h0; ptrByteIn = 8'h00; busGrant = 1'b0; busFree = 1'b1;
    mRdata = 16'h3c3c; mAck = 1'b0; driveStatus = 7'h00; addrSeen = 1'b0;
    errTotal = 0; numChecks = 0; cycles = 0; ackWait = 0; stepRises = 0; lastRise = 0;
    newBase = 32'h0000_1000;
    idle(16);
    rst = 1'b0;
    idle(2);
    check("oe idle", adOe_n, 1'b1);
    check("busy", cmdBusy, 1'b0);
    $display("test reset done");
    motorOn = 1'b1;
    idle(30);
    check("gated", driveCtl[9], 1'b0);
    localMode = 1'b1;
    for (int i = 0; i < 4; i++) begin
      {floppyHeadLoad, writeCompEnable, motorOn, reducedWriteCurrent} = 4'h1 << i;
      idle(30);
      check("levels", driveCtl[11:8], 4'h1 << i);
    end
    $display("test control word done");
    for (int i = 0; i < 7; i++) begin
      driveStatus = 7'h01 << i;
      idle(300);
      check("sense", {writeGuard, trackZero, seekDone, driveReady, driveIndex},
        i < 3 ? 5'h01 << i : (i < 5 ? 5'h08 : 5'h10));
    end
    $display("test status decode done");
    run_cmd(0, 2, 1'b1, 1'b0, 16'h0001, 16'h0003, 5'h05);
    for (int i = 0; i < 4; i++) begin
      ptrByteWe = 4'h1 << i;
      ptrByteIn = newBase[8 * i +: 8];
      idle(1);
    end
    ptrByteWe = 4'h0;
    run_cmd(32'h1000, 1, 1'b1, 1'b1, 16'h0003, 16'h0001, 5'h05);
    run_cmd(32'h1000, 3, 1'b0, 1'b0, 16'h0002, 16'h0007, 5'h09);
    conclude();
  end
endmodule : tb_top
bind ddc_drive_port ddc_port_monitor i_mon (.*);
